// File: dv/ssp_far_model.sv
`timescale 1ns/1ps
module ssp_far_model #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         ext_i,
  input  wire logic         ck_i,
  input  wire logic         fs_i,
  input  wire logic         sd_i,
  input  wire logic         sd_oe_n_i,
  input  wire logic [W-1:0] word_i,
  output logic              ck_o,
  output logic              fs_o,
  output logic              sd_o,
  output logic [W-1:0]      cap_o,
  output int                nbit_o
);
  logic pk, pf;
  int   n, k;
  logic [W-1:0] sh;
  // external clock and one-bit frame sync, own phase
  initial begin
    {ck_o, fs_o, sd_o, pk, pf} = '0;
    {n, k, nbit_o, cap_o} = '0;
    #37;
    forever begin
      #200 ck_o = ext_i & ~ck_o;
      if (ck_o) begin
        k = (k + 1) % W;
        fs_o = ext_i && k == 0;
      end
    end
  end
  // word sent msb first from the frame's first rise
  always @(posedge clk_i) begin
    pk <= ck_i;
    if (ck_i && !pk) begin
      pf <= fs_i;
      if (fs_i && !pf) begin
        n <= 1;
        sh <= word_i << 1;
        sd_o <= word_i[W-1];
      end else if (n > 0 && n < W) begin
        n <= n + 1;
        sd_o <= sh[W-1];
        sh <= sh << 1;
      end else begin
        n <= 0;
        sd_o <= ~sd_o; // idle line keeps moving
      end
    end
    if (!ck_i && pk && !sd_oe_n_i) begin
      cap_o <= {cap_o[W-2:0], sd_i};
      nbit_o <= nbit_o + 1;
    end
  end
endmodule : ssp_far_model

// File: dv/ssp_top_properties.sv
`timescale 1ns/1ps
module ssp_top_properties (
  input wire logic                      clk_i,
  input wire logic                      rstn_i,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_ack_o,
  input wire logic [31:0]               wb_dat_o,
  input wire logic [ssp_pkg::NPORT-1:0] tx_serial_data_oe_n_o,
  input wire logic [ssp_pkg::NPORT-1:0] tx_bit_clock_o,
  input wire logic [ssp_pkg::NPORT-1:0] tx_bit_clock_oe_n_o,
  input wire logic [ssp_pkg::NPORT-1:0] tx_frame_sync_o,
  input wire logic [ssp_pkg::NPORT-1:0] tx_frame_sync_oe_n_o
);
  import ssp_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // bus request and its one-cycle answer
  sequence s_req;
    wb_cyc_i && wb_stb_i;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_pulse: assert property (wb_ack_o |-> s_ans) else $error("ack too long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  c_access: cover property (s_req ##1 s_ans);
  a_one_set: assert property ($onehot0(~tx_bit_clock_oe_n_o))
    else $error("clock driven on two port sets");
  a_data_set: assert property ($onehot0(~tx_serial_data_oe_n_o))
    else $error("data driven on two port sets");
  a_ck_fs_pair: assert property (tx_bit_clock_oe_n_o == tx_frame_sync_oe_n_o)
    else $error("clock and frame sync drive differ");
  a_txd_on_edge: assert property ($changed(tx_serial_data_oe_n_o) &&
    $stable(tx_bit_clock_oe_n_o) && !(&tx_bit_clock_oe_n_o) |-> $changed(tx_bit_clock_o))
    else $error("data drive changed off clock edge");
  a_fs_on_edge: assert property ($changed(tx_frame_sync_o) &&
    $stable(tx_frame_sync_oe_n_o) && !(&tx_frame_sync_oe_n_o) |-> $changed(tx_bit_clock_o))
    else $error("frame sync moved off clock edge");
endmodule : ssp_top_properties

// File: dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_top;
  import ssp_pkg::*;
  localparam int W = 16;
  logic clk_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ext, pol, fsv, fck, ffs, fsd;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, c, d;
  logic [NPORT-1:0] tx_serial_data_o, tx_serial_data_oe_n_o, tx_bit_clock_i, tx_bit_clock_o;
  logic [NPORT-1:0] tx_bit_clock_oe_n_o, tx_frame_sync_i, tx_frame_sync_o, tx_frame_sync_oe_n_o;
  logic [NPORT-1:0] rx_bit_clock_i, rx_frame_sync_i, rx_serial_data_i;
  logic [1:0] p;
  logic [W-1:0] rxw, cap, e;
  logic [W-1:0] expq[$];
  int seed, nb, tgt, nw, error_cnt, n_checks;
  // wire levels from both parties' drives
  assign tx_bit_clock_i = (tx_bit_clock_oe_n_o & {NPORT{fck}}) | (~tx_bit_clock_oe_n_o & tx_bit_clock_o);
  assign tx_frame_sync_i = (tx_frame_sync_oe_n_o & {NPORT{ffs}}) | (~tx_frame_sync_oe_n_o & tx_frame_sync_o);
  assign rx_serial_data_i = {NPORT{fsd}};
  assign rx_bit_clock_i = '0;
  assign rx_frame_sync_i = '0;
  ssp_top #(.WORD_W(W), .FIFO_DEPTH(8)) i_dut (.clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_serial_data_o,
    .tx_serial_data_oe_n_o, .tx_bit_clock_i, .tx_bit_clock_o, .tx_bit_clock_oe_n_o,
    .tx_frame_sync_i, .tx_frame_sync_o, .tx_frame_sync_oe_n_o, .rx_bit_clock_i,
    .rx_bit_clock_o(), .rx_bit_clock_oe_n_o(), .rx_frame_sync_i, .rx_frame_sync_o(),
    .rx_frame_sync_oe_n_o(), .rx_serial_data_i);
  ssp_far_model #(.W(W)) i_far (.clk_i, .ext_i(ext), .ck_i(tx_bit_clock_i[p] ^ pol),
    .fs_i(tx_frame_sync_i[p] ^ fsv), .sd_i(tx_serial_data_o[p]),
    .sd_oe_n_i(tx_serial_data_oe_n_o[p]), .word_i(rxw), .ck_o(fck), .fs_o(ffs),
    .sd_o(fsd), .cap_o(cap), .nbit_o(nb));
  // one classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv,
                    output logic [31:0] r);
    int t;
    t = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, dv};
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 300);
    r = wb_dat_o;
    if (t >= 300) error_cnt++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  // next word seen on the link against the queue
  task automatic take_word();
    int t;
    t = 0;
    tgt += W;
    while (nb < tgt && t < 3000) begin
      @(posedge clk_i);
      t++;
    end
    e = expq.pop_front();
    `CHK("txword", e, t < 3000 ? cap : ~e)
  endtask : take_word
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  initial begin
    clk_i = 0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    #3_000_000;
    error_cnt++;
    test_done();
  end
  // reset values, then one pass per port set, then a fifth pass on set 0 with external clock
  initial begin
    seed = 32'hf5e7;
    {wb_cyc_i, wb_stb_i, wb_we_i, ext, pol, fsv, p, rstn_i} = '0;
    {wb_adr_i, wb_dat_i, rxw} = '0;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    wb(0, ADR_CTRL, 0, q); `CHK("ctrl", CTRL_RST, q)
    wb(0, ADR_DIV, 0, q); `CHK("div", {16'h0000, DIV_RST}, q)
    wb(0, 8'h14, 0, q); `CHK("unmapped", 32'h0000_0000, q)
    wb(1, ADR_DIV, 32'h0000_0007, q);
    for (int i = 0; i < 5; i++) begin
      p = 2'(i);
      ext = (i == 4);
      pol = (i == 1);
      fsv = (i == 2);
      // port, sync, internal, polarities, two slots; rx restarts with tx
      c = (32'(i % 4) << CT_PORT) | (32'(i < 4) * 32'h0000_0c00) | 32'h0000_0004
        | (32'(pol) * 32'h0000_0060) | (32'(fsv) * 32'h0000_0180) | (32'(i == 3) * 32'h0001_0210);
      wb(1, ADR_CTRL, c, q);
      nw = (i == 0) ? 8 : 2;
      for (int j = 0; j < nw; j++) begin
        d = $random(seed);
        expq.push_back(d[15:0]);
        wb(1, ADR_TXD, d, q);
      end
      wb(0, ADR_STAT, 0, q); `CHK("full", nw == 8, q[ST_FULL])
      rxw = 16'($random(seed));
      tgt = nb;
      wb(1, ADR_CTRL, c | 32'h0000_0003, q);
      for (int j = 0; j < nw; j++) take_word();
      if (i < 3) begin
        wb(0, ADR_RXD, 0, q); `CHK("rxword", rxw, q[15:0])
      end
    end
    repeat (400) @(posedge clk_i);
    `CHK("bits", 256, nb)
    test_done();
  end
endmodule : tb_top
bind ssp_top ssp_top_properties i_props (.clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .wb_dat_o, .tx_serial_data_oe_n_o, .tx_bit_clock_o, .tx_bit_clock_oe_n_o, .tx_frame_sync_o,
  .tx_frame_sync_oe_n_o);

// File: hw/ssp_clkgen.sv
`timescale 1ns/1ps
module ssp_clkgen #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             run_i,
  input  wire logic             internal_i,
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic             pin_i,
  input  wire logic             ckp_i,
  output logic                  lvl_o,
  output logic                  rise_o,
  output logic                  fall_o
);
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic             lc;
  logic             term;

  // logical clock level; polarity is undone for an external clock
  always_comb begin
    term     = (cnt == div_i);
    next_cnt = (!run_i || !internal_i || term) ? '0 : cnt + 1'b1;
    if (!run_i) begin
      lvl_o = 1'b0;
    end else if (internal_i) begin
      lvl_o = term ? !lc : lc;
    end else begin
      lvl_o = pin_i ^ ckp_i;
    end
    rise_o = lvl_o && !lc;
    fall_o = !lvl_o && lc;
  end

  // divider and level history
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt <= '0;
      lc  <= 1'b0;
    end else begin
      cnt <= next_cnt;
      lc  <= lvl_o;
    end
  end
endmodule : ssp_clkgen

// File: hw/ssp_fifo.sv
`timescale 1ns/1ps
module ssp_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  logic [AW:0]  next_wp;
  logic [AW:0]  next_rp;
  logic         push;
  logic         pop;

  // full when pointers differ only in the wrap bit
  always_comb begin
    in_ready_o  = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
    out_valid_o = (wp != rp);
    out_data_o  = mem[rp[AW-1:0]];
    push        = in_valid_i && in_ready_o;
    pop         = out_ready_i && out_valid_o;
    next_wp     = push ? wp + 1'b1 : wp;
    next_rp     = pop ? rp + 1'b1 : rp;
  end

  // pointers and storage
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
    if (push) begin
      mem[wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule : ssp_fifo

// File: hw/ssp_top.sv
`timescale 1ns/1ps
module ssp_top #(
  parameter int WORD_W     = 16,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [ssp_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  output logic [ssp_pkg::NPORT-1:0]     tx_serial_data_o,
  output logic [ssp_pkg::NPORT-1:0]     tx_serial_data_oe_n_o,
  input  wire logic [ssp_pkg::NPORT-1:0] tx_bit_clock_i,
  output logic [ssp_pkg::NPORT-1:0]     tx_bit_clock_o,
  output logic [ssp_pkg::NPORT-1:0]     tx_bit_clock_oe_n_o,
  input  wire logic [ssp_pkg::NPORT-1:0] tx_frame_sync_i,
  output logic [ssp_pkg::NPORT-1:0]     tx_frame_sync_o,
  output logic [ssp_pkg::NPORT-1:0]     tx_frame_sync_oe_n_o,
  input  wire logic [ssp_pkg::NPORT-1:0] rx_bit_clock_i,
  output logic [ssp_pkg::NPORT-1:0]     rx_bit_clock_o,
  output logic [ssp_pkg::NPORT-1:0]     rx_bit_clock_oe_n_o,
  input  wire logic [ssp_pkg::NPORT-1:0] rx_frame_sync_i,
  output logic [ssp_pkg::NPORT-1:0]     rx_frame_sync_o,
  output logic [ssp_pkg::NPORT-1:0]     rx_frame_sync_oe_n_o,
  input  wire logic [ssp_pkg::NPORT-1:0] rx_serial_data_i
);
  import ssp_pkg::*;
  if (WORD_W < 2 || WORD_W > 32) begin : g_bad_word
    $error("word width must be 2 to 32");
  end
  localparam logic [4:0] BC_LAST = 5'(WORD_W - 1);
  localparam int         PW      = 5 * NPORT;

  // byte-lane merge for register writes
  function automatic logic [31:0] ssp_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : ssp_merge

  logic [31:0]       ctrl;
  logic [15:0]       div;
  logic              ack;
  logic [31:0]       rdat;
  logic [31:0]       next_ctrl;
  logic [15:0]       next_div;
  logic              next_ack;
  logic [31:0]       next_rdat;
  logic              push;
  logic              rd_rx;
  logic              clr_ovr;
  logic [PW-1:0]     s1;
  logic [PW-1:0]     s2;
  logic [1:0]        port;
  logic              tx_en;
  logic              rx_en;
  logic              sync_m;
  logic              gated_eff;
  logic              t_int;
  logic              r_int;
  logic              word_length_frame_sync;
  logic [4:0]        slot_last;
  logic              f_ready;
  logic              f_valid;
  logic [WORD_W-1:0] f_data;
  logic              pop;
  logic              t_lvl;
  logic              t_rise;
  logic              t_fall;
  logic              rg_lvl;
  logic              rg_rise;
  logic              rg_fall;
  logic              r_lvl;
  logic              r_rise;
  logic              r_fall;
  logic              t_fsl;
  logic              r_fsl;
  logic              t_run;
  logic              t_act;
  logic              t_pend;
  logic              t_fsq;
  logic [4:0]        t_bc;
  logic [4:0]        t_slot;
  logic [WORD_W-1:0] t_sh;
  logic              next_t_run;
  logic              next_t_act;
  logic              next_t_pend;
  logic              next_t_fsq;
  logic [4:0]        next_t_bc;
  logic [4:0]        next_t_slot;
  logic [WORD_W-1:0] next_t_sh;
  logic              r_run;
  logic              r_pend;
  logic              r_fsq;
  logic [4:0]        r_bc;
  logic [4:0]        r_slot;
  logic [WORD_W-1:0] r_sh;
  logic [WORD_W-1:0] rx_word;
  logic              rx_valid;
  logic              rx_ovr;
  logic              next_r_run;
  logic              next_r_pend;
  logic              next_r_fsq;
  logic [4:0]        next_r_bc;
  logic [4:0]        next_r_slot;
  logic [WORD_W-1:0] next_r_sh;
  logic [WORD_W-1:0] next_rx_word;
  logic              next_rx_valid;
  logic              next_rx_ovr;
  logic              word_done;
  logic [5*NPORT-1:0] pout;
  logic [5*NPORT-1:0] poen;
  logic [5*NPORT-1:0] next_pout;
  logic [5*NPORT-1:0] next_poen;

  // configuration fields
  assign port      = ctrl[CT_PORT +: 2];
  assign tx_en     = ctrl[CT_TXEN];
  assign rx_en     = ctrl[CT_RXEN];
  assign sync_m    = ctrl[CT_SYNC];
  assign word_length_frame_sync     = ctrl[CT_FSWL];
  assign t_int     = ctrl[CT_TINT];
  // RQ7 gated excludes network
  assign gated_eff = ctrl[CT_GATED] && !ctrl[CT_NET];
  // RQ5 RQ6 slot count
  assign slot_last = !ctrl[CT_NET] ? 5'h00 :
                     (ctrl[CT_SLOT +: 5] == 5'h00) ? 5'h01 : ctrl[CT_SLOT +: 5];

  // two-flop synchronisers on every link input
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= {rx_serial_data_i, rx_frame_sync_i, rx_bit_clock_i,
             tx_frame_sync_i, tx_bit_clock_i};
      s2 <= s1;
    end
  end

  // RQ8 port set pick
  function automatic logic pick(input int grp, input logic [1:0] ps,
                                input logic [PW-1:0] v);
    return v[grp * NPORT + int'(ps)];
  endfunction : pick

  // RQ16 tx clock source
  ssp_clkgen #(.DIV_W(16)) u_tclk (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .run_i      (tx_en),
    .internal_i (t_int),
    .div_i      (div),
    .pin_i      (pick(PG_TCK, port, s2)),
    .ckp_i      (ctrl[CT_TCKP]),
    .lvl_o      (t_lvl),
    .rise_o     (t_rise),
    .fall_o     (t_fall)
  );

  // RQ2 own rx clock source
  ssp_clkgen #(.DIV_W(16)) u_rclk (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .run_i      (rx_en && !sync_m),
    .internal_i (ctrl[CT_RINT]),
    .div_i      (div),
    .pin_i      (pick(PG_RCK, port, s2)),
    .ckp_i      (ctrl[CT_RCKP]),
    .lvl_o      (rg_lvl),
    .rise_o     (rg_rise),
    .fall_o     (rg_fall)
  );

  // RQ1 RQ11 shared timing in sync mode; RQ15 frame sync polarity
  always_comb begin
    r_int  = sync_m ? t_int : ctrl[CT_RINT];
    r_lvl  = sync_m ? t_lvl : rg_lvl;
    r_rise = sync_m ? t_rise : rg_rise;
    r_fall = sync_m ? t_fall : rg_fall;
    t_fsl  = pick(PG_TFS, port, s2) ^ ctrl[CT_TX_FRAME_SYNC_INVERT];
    r_fsl  = sync_m ? t_fsl : (pick(PG_RFS, port, s2) ^ ctrl[CT_RX_FRAME_SYNC_INVERT]);
  end

  // transmit FIFO between the bus and the shifter
  ssp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (push),
    .in_ready_o  (f_ready),
    .in_data_i   (wb_dat_i[WORD_W-1:0]),
    .out_valid_o (f_valid),
    .out_ready_i (pop),
    .out_data_o  (f_data)
  );

  // wishbone slave; a push into a full FIFO waits for space
  always_comb begin
    next_ctrl = ctrl;
    next_div  = div;
    next_rdat = '0;
    next_ack  = wb_cyc_i && wb_stb_i && !ack &&
                !(wb_we_i && wb_adr_i == ADR_TXD && !f_ready);
    push      = next_ack && wb_we_i && wb_adr_i == ADR_TXD;
    rd_rx     = next_ack && !wb_we_i && wb_adr_i == ADR_RXD;
    clr_ovr   = next_ack && wb_we_i && wb_adr_i == ADR_STAT && wb_sel_i[0] &&
                wb_dat_i[ST_OVR];
    if (next_ack && wb_we_i) begin
      if (wb_adr_i == ADR_CTRL) begin
        next_ctrl = ssp_merge(ctrl, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == ADR_DIV) begin
        next_div = 16'(ssp_merge({16'h0000, div}, wb_dat_i, wb_sel_i));
      end
    end
    if (next_ack && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: next_rdat = ctrl;
        ADR_DIV:  next_rdat = {16'h0000, div};
        ADR_RXD:  next_rdat = 32'(rx_word);
        ADR_STAT: begin
          next_rdat[ST_EMPTY]     = !f_valid;
          next_rdat[ST_FULL]      = !f_ready;
          next_rdat[ST_RXV]       = rx_valid;
          next_rdat[ST_OVR]       = rx_ovr;
          next_rdat[ST_BUSY]      = t_run;
          next_rdat[ST_TSLOT +: 5] = t_slot;
          next_rdat[ST_RSLOT +: 5] = r_slot;
        end
        default:  next_rdat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl <= CTRL_RST;
      div  <= DIV_RST;
      ack  <= 1'b0;
      rdat <= '0;
    end else begin
      ctrl <= next_ctrl;
      div  <= next_div;
      ack  <= next_ack;
      rdat <= next_rdat;
    end
  end
  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;

  // transmit engine: words launched on rising edges
  always_comb begin
    next_t_run  = t_run;
    next_t_act  = t_act;
    next_t_pend = t_pend;
    next_t_fsq  = t_fsq;
    next_t_bc   = t_bc;
    next_t_slot = t_slot;
    next_t_sh   = t_sh;
    pop         = 1'b0;
    if (!tx_en) begin
      next_t_run  = 1'b0;
      next_t_act  = 1'b0;
      next_t_pend = 1'b0;
      next_t_bc   = '0;
      next_t_slot = '0;
    end else begin
      // RQ16 external frame sync seen at fall
      if (t_fall) begin
        next_t_fsq = t_fsl;
        if (!t_int && t_fsl && !t_fsq) begin
          next_t_pend = 1'b1;
        end
      end
      if (t_rise) begin
        // RQ4 gated start needs data
        if (t_pend || (t_int && !t_run && (!gated_eff || f_valid))) begin
          // RQ17 slot restart
          next_t_run  = 1'b1;
          next_t_pend = 1'b0;
          next_t_bc   = '0;
          next_t_slot = '0;
          next_t_act  = f_valid;
          next_t_sh   = f_data;
          pop         = f_valid;
        end else if (t_run && t_bc == BC_LAST) begin
          if ((!t_int && t_slot == slot_last) || (gated_eff && !f_valid)) begin
            next_t_run = 1'b0;
            next_t_act = 1'b0;
          end else begin
            // RQ17 slot advance
            next_t_slot = (t_slot == slot_last) ? 5'h00 : t_slot + 5'h01;
            next_t_bc   = '0;
            next_t_act  = f_valid;
            next_t_sh   = f_data;
            pop         = f_valid;
          end
        end else if (t_run) begin
          // RQ9 launch on rise
          next_t_bc = t_bc + 5'h01;
          next_t_sh = {t_sh[WORD_W-2:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      t_run  <= 1'b0;
      t_act  <= 1'b0;
      t_pend <= 1'b0;
      t_fsq  <= 1'b0;
      t_bc   <= '0;
      t_slot <= '0;
      t_sh   <= '0;
    end else begin
      t_run  <= next_t_run;
      t_act  <= next_t_act;
      t_pend <= next_t_pend;
      t_fsq  <= next_t_fsq;
      t_bc   <= next_t_bc;
      t_slot <= next_t_slot;
      t_sh   <= next_t_sh;
    end
  end

  // receive engine: frame timing on rises, data sampled on falls
  always_comb begin
    next_r_run    = r_run;
    next_r_pend   = r_pend;
    next_r_fsq    = r_fsq;
    next_r_bc     = r_bc;
    next_r_slot   = r_slot;
    next_r_sh     = r_sh;
    next_rx_word  = rx_word;
    word_done     = 1'b0;
    if (!rx_en) begin
      next_r_run  = 1'b0;
      next_r_pend = 1'b0;
      next_r_bc   = '0;
      next_r_slot = '0;
    end else if (r_fall) begin
      next_r_fsq = r_fsl;
      if (!r_int && r_fsl && !r_fsq) begin
        next_r_pend = 1'b1;
      end
      if (r_run) begin
        // RQ10 RQ11 sample on fall
        next_r_sh = {r_sh[WORD_W-2:0], pick(PG_RSD, port, s2)};
        if (r_bc == BC_LAST) begin
          word_done    = 1'b1;
          next_rx_word = next_r_sh;
        end
      end
    end else if (r_rise) begin
      if (r_pend || (r_int && !r_run)) begin
        // RQ17 slot restart
        next_r_run  = 1'b1;
        next_r_pend = 1'b0;
        next_r_bc   = '0;
        next_r_slot = '0;
      end else if (r_run && r_bc == BC_LAST) begin
        if (!r_int && r_slot == slot_last) begin
          next_r_run = 1'b0;
        end else begin
          next_r_slot = (r_slot == slot_last) ? 5'h00 : r_slot + 5'h01;
          next_r_bc   = '0;
        end
      end else if (r_run) begin
        next_r_bc = r_bc + 5'h01;
      end
    end
    // a new word wins over a clear in the same cycle
    next_rx_valid = word_done || (rx_valid && !rd_rx);
    next_rx_ovr   = (word_done && rx_valid && !rd_rx) || (rx_ovr && !clr_ovr);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r_run    <= 1'b0;
      r_pend   <= 1'b0;
      r_fsq    <= 1'b0;
      r_bc     <= '0;
      r_slot   <= '0;
      r_sh     <= '0;
      rx_word  <= '0;
      rx_valid <= 1'b0;
      rx_ovr   <= 1'b0;
    end else begin
      r_run    <= next_r_run;
      r_pend   <= next_r_pend;
      r_fsq    <= next_r_fsq;
      r_bc     <= next_r_bc;
      r_slot   <= next_r_slot;
      r_sh     <= next_r_sh;
      rx_word  <= next_rx_word;
      rx_valid <= next_rx_valid;
      rx_ovr   <= next_rx_ovr;
    end
  end

  // pin values for the selected port set; others stay released
  always_comb begin
    next_pout = '0;
    next_poen = '1;
    for (int p = 0; p < NPORT; p++) begin
      if (port == 2'(p)) begin
        // RQ12 release data between words
        next_pout[PG_TCK * NPORT + p] = next_t_sh[WORD_W-1];
        next_poen[PG_TCK * NPORT + p] = !next_t_act;
        // RQ3 RQ4 RQ14 clock pin
        next_pout[PG_TFS * NPORT + p] = ctrl[CT_TCKP] ^
                                        (t_lvl && (!gated_eff || next_t_run));
        next_poen[PG_TFS * NPORT + p] = !(tx_en && t_int);
        // RQ13 RQ15 frame sync shape
        next_pout[PG_RCK * NPORT + p] = ctrl[CT_TX_FRAME_SYNC_INVERT] ^ (next_t_run &&
                                        next_t_slot == 5'h00 &&
                                        (word_length_frame_sync || next_t_bc == 5'h00));
        next_poen[PG_RCK * NPORT + p] = !(tx_en && t_int);
        // RQ2 rx clock and frame sync
        next_pout[PG_RFS * NPORT + p] = ctrl[CT_RCKP] ^ r_lvl;
        next_poen[PG_RFS * NPORT + p] = !(rx_en && r_int && !sync_m);
        next_pout[PG_RSD * NPORT + p] = ctrl[CT_RX_FRAME_SYNC_INVERT] ^ (next_r_run &&
                                        next_r_slot == 5'h00 &&
                                        (word_length_frame_sync || next_r_bc == 5'h00));
        next_poen[PG_RSD * NPORT + p] = !(rx_en && r_int && !sync_m);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pout <= '0;
      poen <= '1;
    end else begin
      pout <= next_pout;
      poen <= next_poen;
    end
  end

  // output slices: data, clock, frame sync for tx, then clock, frame sync for rx
  assign tx_serial_data_o      = pout[PG_TCK * NPORT +: NPORT];
  assign tx_serial_data_oe_n_o = poen[PG_TCK * NPORT +: NPORT];
  assign tx_bit_clock_o        = pout[PG_TFS * NPORT +: NPORT];
  assign tx_bit_clock_oe_n_o   = poen[PG_TFS * NPORT +: NPORT];
  assign tx_frame_sync_o       = pout[PG_RCK * NPORT +: NPORT];
  assign tx_frame_sync_oe_n_o  = poen[PG_RCK * NPORT +: NPORT];
  assign rx_bit_clock_o        = pout[PG_RFS * NPORT +: NPORT];
  assign rx_bit_clock_oe_n_o   = poen[PG_RFS * NPORT +: NPORT];
  assign rx_frame_sync_o       = pout[PG_RSD * NPORT +: NPORT];
  assign rx_frame_sync_oe_n_o  = poen[PG_RSD * NPORT +: NPORT];
endmodule : ssp_top

// File: pkg/ssp_pkg.sv
// Function
// RQ1 - synchronous mode: transmit and receive share one bit clock and frame sync
// RQ2 - asynchronous mode: each section has its own bit clock and frame sync
// RQ3 - continuous clock mode: bit clock toggles at all times
// RQ4 - gated clock mode: bit clock toggles only while a word is sent; the code gates the transmit clock only, not the asynchronous receive clock
// RQ5 - normal mode: one data word each direction per frame
// RQ6 - network mode: 2 to 32 slot words per frame
// RQ7 - gated clock is never combined with network mode
// RQ8 - serial signals routed to one of four port sets
// RQ9 - transmit data and frame sync change on the active rising bit clock edge
// RQ10 - receive data sampled on the falling receive bit clock edge
// RQ11 - synchronous mode samples receive data on the transmit clock falling edge
// RQ12 - transmit data is high impedance between words
// RQ13 - frame sync lasts one bit or one word, edges on rising clock
// RQ14 - clock polarity bits invert the respective bit clock
// RQ15 - frame sync invert bits make the frame sync active low
// RQ16 - each section's clock and frame sync may be internal or external
// RQ17 - slot counter clears on frame sync, advances per completed word
package ssp_pkg;
  localparam int         WB_AW    = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_DIV  = 8'h04;
  localparam logic [7:0] ADR_TXD  = 8'h08;
  localparam logic [7:0] ADR_RXD  = 8'h0C;
  localparam logic [7:0] ADR_STAT = 8'h10;
  // control register fields
  localparam int CT_TXEN  = 0;
  localparam int CT_RXEN  = 1;
  localparam int CT_SYNC  = 2;
  localparam int CT_GATED = 3;
  localparam int CT_NET   = 4;
  localparam int CT_TCKP  = 5;
  localparam int CT_RCKP  = 6;
  localparam int CT_TX_FRAME_SYNC_INVERT  = 7;
  localparam int CT_RX_FRAME_SYNC_INVERT  = 8;
  localparam int CT_FSWL  = 9;
  localparam int CT_TINT  = 10;
  localparam int CT_RINT  = 11;
  localparam int CT_PORT  = 12;
  localparam int CT_SLOT  = 16;
  // status register fields
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL  = 1;
  localparam int ST_RXV   = 2;
  localparam int ST_OVR   = 3;
  localparam int ST_BUSY  = 4;
  localparam int ST_TSLOT = 8;
  localparam int ST_RSLOT = 16;
  localparam logic [31:0] CTRL_RST = 32'h0001_0000;
  // default internal bit clock rate
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          BIT_PERIOD_NS = 400;
  localparam logic [15:0] DIV_RST = 16'(BIT_PERIOD_NS / (2 * CLK_PERIOD_NS) - 1);
  // pin groups, each one bit per port set
  localparam int NPORT  = 4;
  localparam int PG_TCK = 0;
  localparam int PG_TFS = 1;
  localparam int PG_RCK = 2;
  localparam int PG_RFS = 3;
  localparam int PG_RSD = 4;
endpackage : ssp_pkg
